/* design/lcd_timing_pkg.sv */
// constants shared by the display timing generator and its power sequencer
package lcd_timing_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_DISPLAY_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PANEL_TYPE = 8'h04;
	localparam logic [7:0] OFF_HORIZ_CHAR_COUNT = 8'h08;
	localparam logic [7:0] OFF_HORIZ_SYNC = 8'h0C;
	localparam logic [7:0] OFF_VERT_ACTIVE_LINES = 8'h10;
	localparam logic [7:0] OFF_VERT_TOTAL_LINES = 8'h14;
	localparam logic [7:0] OFF_VERT_SYNC = 8'h18;
	localparam logic [7:0] OFF_POWER_MGMT_MODE = 8'h1C;
	localparam logic [7:0] OFF_POWER_SEQ_PERIOD = 8'h20;
	localparam logic [7:0] OFF_FETCH_START_ADDR = 8'h24;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_DISPLAY_ON_BIT = 0;
	localparam int PT_FRAME_SYNC_LOW_BIT = 0;
	localparam int PT_LINE_SYNC_LOW_BIT = 1;
	localparam int PT_DE_LOW_BIT = 2;
	localparam int PT_DATA_LOW_BIT = 3;
	localparam int PT_LINE_SYNC_VBLANK_OFF_BIT = 4;
	localparam int PT_PIXCLK_BLANK_OFF_BIT = 5;
	localparam int PT_DE_OUTPUT_EN_BIT = 6;
	localparam int PT_PANEL_KIND_LSB = 8;
	localparam int PT_BUS_WIDTH_LSB = 12;
	localparam int HCOUNT_TOTAL_LSB = 0;
	localparam int HCOUNT_ACTIVE_LSB = 16;
	localparam int SYNC_START_LSB = 0;
	localparam int SYNC_PULSE_LSB = 16;
	localparam int PM_USE_OUTPUTS_BIT = 0;
	localparam int PM_STATE_LSB = 8;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int HCHAR_W = 8;
	localparam int VLINE_W = 11;
	localparam int PULSE_W = 4;
	localparam int INTERVAL_W = 8;
	localparam int PIXEL_W = 18;
	localparam int CHAR_PIXELS = 8;
	localparam int DOT_W = 3;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [31:0] PANEL_TYPE_RESET = 32'h0000_3040;
	localparam logic [31:0] FETCH_ADDR_RESET = 32'h0000_0000;
	localparam logic [1:0] PANEL_SINGLE_PASSIVE = 2'h0;
	localparam logic [1:0] PANEL_DUAL_SCAN_PASSIVE = 2'h1;
	localparam logic [1:0] PANEL_ACTIVE_MATRIX = 2'h2;
	localparam logic [2:0] BUS_W4 = 3'h0;
	localparam logic [2:0] BUS_W8 = 3'h1;
	localparam logic [2:0] BUS_W12 = 3'h2;
	localparam logic [2:0] BUS_W16 = 3'h3;
	localparam logic [2:0] BUS_W18 = 3'h4;
	localparam logic [1:0] PSTATE_STOPPED = 2'h0;
	localparam logic [1:0] PSTATE_STARTING = 2'h1;
	localparam logic [1:0] PSTATE_STOPPING = 2'h2;
	localparam logic [1:0] PSTATE_STARTED = 2'h3;

	typedef enum logic [5:0] {
		PS_OFF = 6'h01,
		PS_UP_LOGIC = 6'h02,
		PS_UP_DRIVER = 6'h04,
		PS_ON = 6'h08,
		PS_DN_DISPLAY = 6'h10,
		PS_DN_DRIVER = 6'h20
	} power_state_t;

endpackage : lcd_timing_pkg

/* design/panel_power_seq.sv */
// frame-paced power-up and power-down sequencer for the panel supplies
`timescale 1ns/1ps
module panel_power_seq #(
	parameter int INTERVAL_W = lcd_timing_pkg::INTERVAL_W
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_display_on,
	input wire logic i_frame_end,
	input wire logic i_use_outputs,
	input wire logic [INTERVAL_W-1:0] i_interval,
	output logic o_logic_supply_ctl,
	output logic o_driver_supply_ctl,
	output logic o_display_on_ctl,
	output logic o_running,
	output logic [1:0] o_state_bits
);

	lcd_timing_pkg::power_state_t state_r, state_nxt;
	logic [INTERVAL_W-1:0] gap_r, gap_nxt;
	logic gap_done;

	// frame ends counted, so PS_DN_DISPLAY may end on a partial frame; a zero interval moves on at once
	assign gap_done = (gap_r >= i_interval);

	always_comb begin
		state_nxt = state_r;
		gap_nxt = gap_r;
		if (i_frame_end && !gap_done) begin
			gap_nxt = gap_r + {{(INTERVAL_W-1){1'b0}}, 1'b1};
		end
		case (state_r)
			lcd_timing_pkg::PS_OFF: begin
				gap_nxt = '0;
				if (i_display_on) begin
					state_nxt = lcd_timing_pkg::PS_UP_LOGIC;
				end
			end
			lcd_timing_pkg::PS_UP_LOGIC: begin
				if (gap_done) begin
					state_nxt = lcd_timing_pkg::PS_UP_DRIVER;
					gap_nxt = '0;
				end
			end
			lcd_timing_pkg::PS_UP_DRIVER: begin
				if (gap_done) begin
					state_nxt = lcd_timing_pkg::PS_ON;
					gap_nxt = '0;
				end
			end
			lcd_timing_pkg::PS_ON: begin
				gap_nxt = '0;
				if (!i_display_on) begin
					state_nxt = lcd_timing_pkg::PS_DN_DISPLAY;
				end
			end
			lcd_timing_pkg::PS_DN_DISPLAY: begin
				if (gap_done) begin
					state_nxt = lcd_timing_pkg::PS_DN_DRIVER;
					gap_nxt = '0;
				end
			end
			lcd_timing_pkg::PS_DN_DRIVER: begin
				if (gap_done) begin
					state_nxt = lcd_timing_pkg::PS_OFF;
					gap_nxt = '0;
				end
			end
			default: begin
				state_nxt = lcd_timing_pkg::PS_OFF;
				gap_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_r <= lcd_timing_pkg::PS_OFF;
			gap_r <= '0;
		end else begin
			state_r <= state_nxt;
			gap_r <= gap_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic up_logic, up_driver, up_display;
	assign up_logic = (state_r != lcd_timing_pkg::PS_OFF);
	assign up_driver = (state_r == lcd_timing_pkg::PS_UP_DRIVER) ||
		(state_r == lcd_timing_pkg::PS_ON) ||
		(state_r == lcd_timing_pkg::PS_DN_DISPLAY);
	assign up_display = (state_r == lcd_timing_pkg::PS_ON);
	assign o_logic_supply_ctl = up_logic && i_use_outputs;
	assign o_driver_supply_ctl = up_driver && i_use_outputs;
	assign o_display_on_ctl = up_display && i_use_outputs;
	assign o_running = up_logic;

	always_comb begin
		case (state_r)
			lcd_timing_pkg::PS_OFF: o_state_bits = lcd_timing_pkg::PSTATE_STOPPED;
			lcd_timing_pkg::PS_ON: o_state_bits = lcd_timing_pkg::PSTATE_STARTED;
			lcd_timing_pkg::PS_UP_LOGIC,
			lcd_timing_pkg::PS_UP_DRIVER: o_state_bits = lcd_timing_pkg::PSTATE_STARTING;
			default: o_state_bits = lcd_timing_pkg::PSTATE_STOPPING;
		endcase
	end

endmodule : panel_power_seq

/* design/lcd_sync_timing_power_sequencer.sv */
// display timing generator with register port and panel power sequencing
`timescale 1ns/1ps

module lcd_sync_timing_power_sequencer #(
	parameter int PIXEL_W = lcd_timing_pkg::PIXEL_W
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_pixel_clock,
	input wire logic [PIXEL_W-1:0] i_pixel_data,
	output logic o_pixel_req,
	output logic [PIXEL_W-1:0] o_pixel_data,
	output logic o_line_sync_out,
	output logic o_frame_sync_out,
	output logic o_pixel_clock_out,
	output logic o_display_enable_out,
	output logic o_logic_supply_ctl,
	output logic o_driver_supply_ctl,
	output logic o_display_on_ctl,
	output logic o_frame_end,
	output logic [31:0] o_fetch_addr
);

	localparam int HW = lcd_timing_pkg::HCHAR_W;
	localparam int VW = lcd_timing_pkg::VLINE_W;
	localparam int PW = lcd_timing_pkg::PULSE_W;
	localparam int IW = lcd_timing_pkg::INTERVAL_W;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] ctl_r, ctl_nxt;
	logic [31:0] ptype_r, ptype_nxt;
	logic [31:0] hcount_r, hcount_nxt;
	logic [31:0] hsync_r, hsync_nxt;
	logic [31:0] vactive_r, vactive_nxt;
	logic [31:0] vtotal_r, vtotal_nxt;
	logic [31:0] vsync_r, vsync_nxt;
	logic [31:0] pmode_r, pmode_nxt;
	logic [31:0] pperiod_r, pperiod_nxt;
	logic [31:0] fetch_r, fetch_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] pstate;
	logic running;

	always_comb begin
		ctl_nxt = ctl_r;
		ptype_nxt = ptype_r;
		hcount_nxt = hcount_r;
		hsync_nxt = hsync_r;
		vactive_nxt = vactive_r;
		vtotal_nxt = vtotal_r;
		vsync_nxt = vsync_r;
		pmode_nxt = pmode_r;
		pperiod_nxt = pperiod_r;
		fetch_nxt = fetch_r;
		rdata_nxt = 32'h0000_0000;
		if (i_wr) begin
			case (i_addr)
				lcd_timing_pkg::OFF_DISPLAY_CONTROL: ctl_nxt = i_wdata;
				lcd_timing_pkg::OFF_PANEL_TYPE: ptype_nxt = i_wdata;
				lcd_timing_pkg::OFF_HORIZ_CHAR_COUNT: hcount_nxt = i_wdata;
				lcd_timing_pkg::OFF_HORIZ_SYNC: hsync_nxt = i_wdata;
				lcd_timing_pkg::OFF_VERT_ACTIVE_LINES: vactive_nxt = i_wdata;
				lcd_timing_pkg::OFF_VERT_TOTAL_LINES: vtotal_nxt = i_wdata;
				lcd_timing_pkg::OFF_VERT_SYNC: vsync_nxt = i_wdata;
				lcd_timing_pkg::OFF_POWER_MGMT_MODE: pmode_nxt = i_wdata;
				lcd_timing_pkg::OFF_POWER_SEQ_PERIOD: pperiod_nxt = i_wdata;
				lcd_timing_pkg::OFF_FETCH_START_ADDR: fetch_nxt = i_wdata;
				default: ctl_nxt = ctl_r;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				lcd_timing_pkg::OFF_DISPLAY_CONTROL: rdata_nxt = ctl_r;
				lcd_timing_pkg::OFF_PANEL_TYPE: rdata_nxt = ptype_r;
				lcd_timing_pkg::OFF_HORIZ_CHAR_COUNT: rdata_nxt = hcount_r;
				lcd_timing_pkg::OFF_HORIZ_SYNC: rdata_nxt = hsync_r;
				lcd_timing_pkg::OFF_VERT_ACTIVE_LINES: rdata_nxt = vactive_r;
				lcd_timing_pkg::OFF_VERT_TOTAL_LINES: rdata_nxt = vtotal_r;
				lcd_timing_pkg::OFF_VERT_SYNC: rdata_nxt = vsync_r;
				lcd_timing_pkg::OFF_POWER_MGMT_MODE: begin
					rdata_nxt = pmode_r;
					rdata_nxt[lcd_timing_pkg::PM_STATE_LSB +: 2] = pstate;
				end
				lcd_timing_pkg::OFF_POWER_SEQ_PERIOD: rdata_nxt = pperiod_r;
				lcd_timing_pkg::OFF_FETCH_START_ADDR: rdata_nxt = fetch_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctl_r <= 32'h0000_0000;
			ptype_r <= lcd_timing_pkg::PANEL_TYPE_RESET;
			hcount_r <= 32'h0000_0000;
			hsync_r <= 32'h0000_0000;
			vactive_r <= 32'h0000_0000;
			vtotal_r <= 32'h0000_0000;
			vsync_r <= 32'h0000_0000;
			pmode_r <= 32'h0000_0000;
			pperiod_r <= 32'h0000_0000;
			fetch_r <= lcd_timing_pkg::FETCH_ADDR_RESET;
			rdata_r <= 32'h0000_0000;
		end else begin
			ctl_r <= ctl_nxt;
			ptype_r <= ptype_nxt;
			hcount_r <= hcount_nxt;
			hsync_r <= hsync_nxt;
			vactive_r <= vactive_nxt;
			vtotal_r <= vtotal_nxt;
			vsync_r <= vsync_nxt;
			pmode_r <= pmode_nxt;
			pperiod_r <= pperiod_nxt;
			fetch_r <= fetch_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign o_rdata = rdata_r;

	// pmode state bits are stored as written but always read live
	logic [HW-1:0] h_total, h_active, h_start;
	logic [VW-1:0] v_total, v_active, v_start;
	logic [PW-1:0] h_pulse, v_pulse;
	logic [2:0] bus_w;
	assign h_total = hcount_r[lcd_timing_pkg::HCOUNT_TOTAL_LSB +: HW];
	assign h_active = hcount_r[lcd_timing_pkg::HCOUNT_ACTIVE_LSB +: HW];
	assign h_start = hsync_r[lcd_timing_pkg::SYNC_START_LSB +: HW];
	assign h_pulse = hsync_r[lcd_timing_pkg::SYNC_PULSE_LSB +: PW];
	assign v_active = vactive_r[VW-1:0];
	assign v_total = vtotal_r[VW-1:0];
	assign v_start = vsync_r[lcd_timing_pkg::SYNC_START_LSB +: VW];
	assign v_pulse = vsync_r[lcd_timing_pkg::SYNC_PULSE_LSB +: PW];
	assign bus_w = ptype_r[lcd_timing_pkg::PT_BUS_WIDTH_LSB +: 3];

	// ------------------------------------------------------------
	// pixel clock sampling
	// ------------------------------------------------------------
	// pixel clock must stay under half the system rate to be seen
	logic pclk_s1_r, pclk_s2_r, pclk_s3_r;
	logic dot_tick;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pclk_s1_r <= 1'b0;
			pclk_s2_r <= 1'b0;
			pclk_s3_r <= 1'b0;
		end else begin
			pclk_s1_r <= i_pixel_clock;
			pclk_s2_r <= pclk_s1_r;
			pclk_s3_r <= pclk_s2_r;
		end
	end
	assign dot_tick = pclk_s2_r && !pclk_s3_r && running;

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	logic [lcd_timing_pkg::DOT_W-1:0] dot_r, dot_nxt;
	logic [HW-1:0] hchar_r, hchar_nxt;
	logic [VW-1:0] line_r, line_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic char_end, line_end, frame_end;

	assign char_end = dot_tick &&
		(dot_r == lcd_timing_pkg::DOT_W'(lcd_timing_pkg::CHAR_PIXELS - 1));
	// total field is length minus one
	assign line_end = char_end && (hchar_r >= h_total);
	assign frame_end = line_end && (line_r >= v_total);

	always_comb begin
		dot_nxt = dot_r;
		hchar_nxt = hchar_r;
		line_nxt = line_r;
		addr_nxt = addr_r;
		if (dot_tick) begin
			dot_nxt = dot_r + 3'h1;
		end
		if (char_end) begin
			hchar_nxt = line_end ? '0 : hchar_r + {{(HW-1){1'b0}}, 1'b1};
		end
		if (line_end) begin
			line_nxt = frame_end ? '0 : line_r + {{(VW-1){1'b0}}, 1'b1};
		end
		if (frame_end || !running) begin
			addr_nxt = fetch_r;
		end
		if (!running) begin
			dot_nxt = '0;
			hchar_nxt = '0;
			line_nxt = '0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			dot_r <= '0;
			hchar_r <= '0;
			line_r <= '0;
			addr_r <= lcd_timing_pkg::FETCH_ADDR_RESET;
		end else begin
			dot_r <= dot_nxt;
			hchar_r <= hchar_nxt;
			line_r <= line_nxt;
			addr_r <= addr_nxt;
		end
	end
	assign o_fetch_addr = addr_r;
	assign o_frame_end = frame_end;

	// ------------------------------------------------------------
	// window decode
	// ------------------------------------------------------------
	logic [HW:0] hs_first, hs_last;
	logic [VW:0] vs_first, vs_last;
	logic h_act, v_act, h_sync, v_sync, in_active;
	assign h_act = (hchar_r <= h_active);
	assign v_act = (line_r <= v_active);
	assign in_active = h_act && v_act && running;
	// pulse starts at start plus one
	assign hs_first = {1'b0, h_start} + (HW+1)'(1);
	assign hs_last = hs_first + (HW+1)'(h_pulse);
	assign h_sync = running && ({1'b0, hchar_r} >= hs_first) &&
		({1'b0, hchar_r} <= hs_last);
	// start field is position minus two
	assign vs_first = {1'b0, v_start} + (VW+1)'(2);
	assign vs_last = vs_first + (VW+1)'(v_pulse);
	assign v_sync = running && ({1'b0, line_r} >= vs_first) &&
		({1'b0, line_r} <= vs_last);

	logic [PIXEL_W-1:0] width_mask;
	// drive only the selected bus width
	always_comb begin
		case (bus_w)
			lcd_timing_pkg::BUS_W4: width_mask = PIXEL_W'(18'h0000F);
			lcd_timing_pkg::BUS_W8: width_mask = PIXEL_W'(18'h000FF);
			lcd_timing_pkg::BUS_W12: width_mask = PIXEL_W'(18'h00FFF);
			lcd_timing_pkg::BUS_W16: width_mask = PIXEL_W'(18'h0FFFF);
			default: width_mask = PIXEL_W'(18'h3FFFF);
		endcase
	end

	// ------------------------------------------------------------
	// panel outputs
	// ------------------------------------------------------------
	logic hs_out_r, hs_out_nxt, vs_out_r, vs_out_nxt;
	logic de_out_r, de_out_nxt, pclk_out_r, pclk_out_nxt;
	logic [PIXEL_W-1:0] pix_r, pix_nxt;
	logic hs_gate, pclk_run;
	logic act_r, act_nxt;

	// window held per dot so enable and clock line up with the data
	assign act_nxt = dot_tick ? in_active : (act_r && running);

	assign hs_gate = h_sync && (v_act ||
		!ptype_r[lcd_timing_pkg::PT_LINE_SYNC_VBLANK_OFF_BIT]);
	assign pclk_run = running && (act_nxt ||
		!ptype_r[lcd_timing_pkg::PT_PIXCLK_BLANK_OFF_BIT]);

	always_comb begin
		hs_out_nxt = hs_gate ^ ptype_r[lcd_timing_pkg::PT_LINE_SYNC_LOW_BIT];
		vs_out_nxt = v_sync ^ ptype_r[lcd_timing_pkg::PT_FRAME_SYNC_LOW_BIT];
		de_out_nxt = act_nxt ^ ptype_r[lcd_timing_pkg::PT_DE_LOW_BIT];
		if (!ptype_r[lcd_timing_pkg::PT_DE_OUTPUT_EN_BIT]) begin
			de_out_nxt = 1'b0;
		end
		pclk_out_nxt = pclk_run && pclk_s2_r;
		pix_nxt = pix_r;
		if (dot_tick) begin
			pix_nxt = '0;
			if (in_active) begin
				pix_nxt = (i_pixel_data ^
					{PIXEL_W{ptype_r[lcd_timing_pkg::PT_DATA_LOW_BIT]}}) &
					width_mask;
			end
		end
		if (!running) begin
			pix_nxt = '0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			hs_out_r <= 1'b0;
			vs_out_r <= 1'b0;
			de_out_r <= 1'b0;
			pclk_out_r <= 1'b0;
			pix_r <= '0;
			act_r <= 1'b0;
		end else begin
			act_r <= act_nxt;
			hs_out_r <= hs_out_nxt;
			vs_out_r <= vs_out_nxt;
			de_out_r <= de_out_nxt;
			pclk_out_r <= pclk_out_nxt;
			pix_r <= pix_nxt;
		end
	end
	assign o_line_sync_out = hs_out_r;
	assign o_frame_sync_out = vs_out_r;
	assign o_display_enable_out = de_out_r;
	assign o_pixel_clock_out = pclk_out_r;
	assign o_pixel_data = pix_r;
	assign o_pixel_req = dot_tick && in_active;

	// ------------------------------------------------------------
	// power sequencing
	// ------------------------------------------------------------
	panel_power_seq #(
		.INTERVAL_W(IW)
	) u_power_seq (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_display_on(ctl_r[lcd_timing_pkg::CTL_DISPLAY_ON_BIT]),
		.i_frame_end(frame_end),
		.i_use_outputs(pmode_r[lcd_timing_pkg::PM_USE_OUTPUTS_BIT]),
		.i_interval(pperiod_r[IW-1:0]),
		.o_logic_supply_ctl(o_logic_supply_ctl),
		.o_driver_supply_ctl(o_driver_supply_ctl),
		.o_display_on_ctl(o_display_on_ctl),
		.o_running(running),
		.o_state_bits(pstate)
	);

endmodule : lcd_sync_timing_power_sequencer

/* verif/lcd_timing_asserts.sv */
// port checker for the display timing and power sequencer block
`timescale 1ns/1ps
module lcd_timing_asserts (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_logic_supply_ctl,
	input wire logic o_driver_supply_ctl,
	input wire logic o_display_on_ctl,
	input wire logic o_frame_end,
	input wire logic [31:0] o_fetch_addr
);
	// ------------------------------------------------------------
	// shadow of interval and use bit
	// ------------------------------------------------------------
	// gaps only mean frames when the interval is nonzero
	logic [7:0] ivl_r;
	logic [7:0] ivl_nxt;
	logic use_r;
	logic use_nxt;
	always_comb begin
		ivl_nxt = ivl_r;
		use_nxt = use_r;
		if (i_wr && i_addr == lcd_timing_pkg::OFF_POWER_SEQ_PERIOD) begin
			ivl_nxt = i_wdata[7:0];
		end
		if (i_wr && i_addr == lcd_timing_pkg::OFF_POWER_MGMT_MODE) begin
			use_nxt = i_wdata[0];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		ivl_r <= i_reset ? 8'h00 : ivl_nxt;
		use_r <= i_reset ? 1'b0 : use_nxt;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_start_wr;
		use_r && i_wr && i_addr == lcd_timing_pkg::OFF_DISPLAY_CONTROL
			&& i_wdata[0];
	endsequence
	sequence s_stop_wr;
		i_wr && i_addr == lcd_timing_pkg::OFF_DISPLAY_CONTROL
			&& i_wdata == 32'h0000_0000;
	endsequence
	a_start_logic_up: assert property (s_start_wr |-> ##[1:3]
		o_logic_supply_ctl) else $error("logic supply not raised");
	a_stop_display_down: assert property (s_stop_wr |-> ##[1:3]
		!o_display_on_ctl) else $error("display control not lowered");
	a_logic_first: assert property ($rose(o_driver_supply_ctl) |->
		$past(o_logic_supply_ctl)) else $error("driver before logic");
	a_driver_under_logic: assert property (o_driver_supply_ctl |->
		o_logic_supply_ctl) else $error("driver on without logic");
	a_display_under_driver: assert property (o_display_on_ctl |->
		o_driver_supply_ctl) else $error("display on without driver");
	a_gap_frame_end: assert property (($rose(o_driver_supply_ctl)
		|| $rose(o_display_on_ctl)) && ivl_r != 8'h00 && $past(use_r)
		|-> $past(o_frame_end) || $past(o_frame_end, 2))
		else $error("power step off frame boundary");
	a_fetch_at_frame: assert property ($changed(o_fetch_addr)
		&& $past(o_display_on_ctl) |-> $past(o_frame_end))
		else $error("fetch address changed mid frame");
	a_frame_end_pulse: assert property (o_frame_end |=>
		!o_frame_end) else $error("frame end longer than one cycle");
	a_interval_readback: assert property (i_rd && i_addr ==
		lcd_timing_pkg::OFF_POWER_SEQ_PERIOD |=> o_rdata[7:0] ==
		$past(ivl_r)) else $error("interval readback wrong");
endmodule : lcd_timing_asserts

bind lcd_sync_timing_power_sequencer lcd_timing_asserts u_chk (
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_logic_supply_ctl(o_logic_supply_ctl),
	.o_driver_supply_ctl(o_driver_supply_ctl),
	.o_display_on_ctl(o_display_on_ctl), .o_frame_end(o_frame_end),
	.o_fetch_addr(o_fetch_addr));

/* verif/panel_model.sv */
// panel-side model: free dot clock source and pixel data feed
`timescale 1ns/1ps
module panel_model #(
	parameter int PIXEL_W = 18,
	parameter logic [PIXEL_W-1:0] PATTERN = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_pixel_req,
	output logic o_pixel_clock,
	output logic [PIXEL_W-1:0] o_pixel_data
);
	// ------------------------------------------------------------
	// dot clock and data feed
	// ------------------------------------------------------------
	logic [PIXEL_W-1:0] junk_r = '0;
	initial begin
		o_pixel_clock = 1'b0;
		#37;
		forever #62.5 o_pixel_clock = ~o_pixel_clock;
	end
	// junk moves every cycle so a late sample is caught
	always_ff @(posedge i_clk_sys) junk_r <= junk_r + 1'b1;
	assign o_pixel_data = i_pixel_req ? PATTERN : junk_r;
endmodule : panel_model

/* verif/tb_top.sv */
// self-checking bench: registers, sync timing, gating, power sequence
`timescale 1ns/1ps
module tb_top;
	localparam logic [17:0] PAT = 18'h2D3A5;
	localparam logic [31:0] PT [6] = '{32'h0000_2048, 32'h0000_0158,
		32'h0000_1268, 32'h0000_4043, 32'h0000_3044, 32'h0000_4008};
	// pixel bus masks for the widths selected above
	localparam logic [17:0] MSK [6] = '{18'h00FFF, 18'h0000F, 18'h000FF,
		18'h3FFFF, 18'h0FFFF, 18'h3FFFF};
	logic i_clk_sys, i_reset, i_wr, i_rd, pix_clk, pix_req, ls, fs, pco, de;
	logic sup_l, sup_d, sup_on, fend, ls_act, fs_act, de_act;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, fetch, q;
	logic [17:0] pix_in, pix_out, px_exp;
	int fails, check_count, n_ls, n_lw, n_fs, n_pc, n_req, n_de, n_bad, n;
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	lcd_sync_timing_power_sequencer dut (.i_clk_sys(i_clk_sys),
		.i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_pixel_clock(pix_clk),
		.i_pixel_data(pix_in), .o_pixel_req(pix_req), .o_pixel_data(pix_out),
		.o_line_sync_out(ls), .o_frame_sync_out(fs), .o_pixel_clock_out(pco),
		.o_display_enable_out(de), .o_logic_supply_ctl(sup_l),
		.o_driver_supply_ctl(sup_d), .o_display_on_ctl(sup_on),
		.o_frame_end(fend), .o_fetch_addr(fetch));
	panel_model #(.PIXEL_W(18), .PATTERN(PAT)) u_panel (.i_clk_sys(i_clk_sys),
		.i_pixel_req(pix_req), .o_pixel_clock(pix_clk), .o_pixel_data(pix_in));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		q = o_rdata;
	endtask : rd
	// counts one whole frame, frame end to frame end
	task automatic frame();
		logic p_ls, p_fs, p_pc, p_de;
		{n_ls, n_lw, n_fs, n_pc, n_req, n_de, n_bad, n} = '0;
		while (fend !== 1'b1 && n < 20000) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		{p_ls, p_fs, p_pc, p_de} = {ls, fs, pco, de};
		do begin
			@(posedge i_clk_sys);
			#1;
			n++;
			if (ls === ls_act && p_ls !== ls_act) n_ls++;
			if (ls === ls_act) n_lw++;
			if (fs === fs_act && p_fs !== fs_act) n_fs++;
			if (pco === 1'b1 && p_pc !== 1'b1) n_pc++;
			if (de === de_act && p_de !== de_act) n_de++;
			if (pix_req === 1'b1) n_req++;
			if (de === de_act && p_de === de_act && pix_out !== px_exp) n_bad++;
			{p_ls, p_fs, p_pc, p_de} = {ls, fs, pco, de};
		end while (fend !== 1'b1 && n < 40000);
		if (fend !== 1'b1) fails++;
	endtask : frame
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (95000) @(posedge i_clk_sys);
		fails++;
		finish_test();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{i_reset, i_addr, i_wdata, i_wr, i_rd} = {1'b1, 42'h0};
		{ls_act, fs_act, de_act, px_exp} = {3'b111, ~PAT};
		repeat (12) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		rd(lcd_timing_pkg::OFF_PANEL_TYPE);
		check(q, lcd_timing_pkg::PANEL_TYPE_RESET);
		rd(8'hFC);
		check(q, 32'h0000_0000);
		rd(lcd_timing_pkg::OFF_POWER_MGMT_MODE);
		check({30'h0, q[9:8]}, {30'h0, lcd_timing_pkg::PSTATE_STOPPED});
		wr(lcd_timing_pkg::OFF_HORIZ_CHAR_COUNT, 32'h0001_0003);
		wr(lcd_timing_pkg::OFF_HORIZ_SYNC, 32'h0000_0002);
		wr(lcd_timing_pkg::OFF_VERT_ACTIVE_LINES, 32'h0000_0001);
		wr(lcd_timing_pkg::OFF_VERT_TOTAL_LINES, 32'h0000_0002);
		wr(lcd_timing_pkg::OFF_VERT_SYNC, 32'h0000_0000);
		wr(lcd_timing_pkg::OFF_POWER_SEQ_PERIOD, 32'h0000_0001);
		rd(lcd_timing_pkg::OFF_POWER_SEQ_PERIOD);
		check({24'h0, q[7:0]}, 32'h0000_0001);
		wr(lcd_timing_pkg::OFF_POWER_MGMT_MODE, 32'h0000_0001);
		// no interrupt source to enable first
		wr(lcd_timing_pkg::OFF_DISPLAY_CONTROL, 32'h0000_0011);
		frame();
		check({29'h0, sup_l, sup_d, sup_on}, 32'h0000_0006);
		repeat (2) frame();
		check({29'h0, sup_l, sup_d, sup_on}, 32'h0000_0007);
		rd(lcd_timing_pkg::OFF_POWER_MGMT_MODE);
		check({30'h0, q[9:8]}, {30'h0, lcd_timing_pkg::PSTATE_STARTED});
		$display("test power up done");
		for (int i = 0; i < 6; i++) begin
			wr(lcd_timing_pkg::OFF_PANEL_TYPE, PT[i]);
			{ls_act, fs_act, de_act} = {!PT[i][1], !PT[i][0], !PT[i][2]};
			px_exp = (PT[i][3] ? ~PAT : PAT) & MSK[i];
			frame();
			frame();
			check(32'(n_ls), PT[i][4] ? 32'h2 : 32'h3);
			check({31'h0, n_lw inside {[(PT[i][4] ? 485 : 735) :
				(PT[i][4] ? 515 : 765)]}}, 32'h1);
			check(32'(n_fs), 32'h1);
			check(32'(n_pc), PT[i][5] ? 32'h20 : 32'h60);
			check(32'(n_de), PT[i][6] ? 32'h2 : 32'h0);
			check(32'(n_req), 32'h20);
			check(32'(n_bad), 32'h0);
			$display("test options %0d done", i);
		end
		wr(lcd_timing_pkg::OFF_FETCH_START_ADDR, 32'h0000_8000);
		#1;
		check(fetch, lcd_timing_pkg::FETCH_ADDR_RESET);
		frame();
		check(fetch, 32'h0000_8000);
		$display("test fetch address done");
		wr(lcd_timing_pkg::OFF_DISPLAY_CONTROL, 32'h0000_0000);
		for (n = 0; n < 20000 && sup_l !== 1'b0; n++) @(posedge i_clk_sys);
		check({29'h0, sup_l, sup_d, sup_on}, 32'h0000_0000);
		rd(lcd_timing_pkg::OFF_POWER_MGMT_MODE);
		check({30'h0, q[9:8]}, {30'h0, lcd_timing_pkg::PSTATE_STOPPED});
		wr(lcd_timing_pkg::OFF_POWER_MGMT_MODE, 32'h0000_0000);
		wr(lcd_timing_pkg::OFF_DISPLAY_CONTROL, 32'h0000_0011);
		repeat (3) frame();
		rd(lcd_timing_pkg::OFF_POWER_MGMT_MODE);
		check({30'h0, q[9:8]}, {30'h0, lcd_timing_pkg::PSTATE_STARTED});
		check({29'h0, sup_l, sup_d, sup_on}, 32'h0000_0000);
		$display("test unused outputs done");
		finish_test();
	end
endmodule : tb_top
